/* File: hdl/decoder_defs.svh */
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH

`define MASTERS 6
`define M_CPU 0
`define M_USB 5
`define ADDR_W 24
`define BLK_W 5

`define MMR_TOP 24'h0000BF
`define DUAL_ACCESS_RAM_TOP 24'h00FFFF
`define SINGLE_ACCESS_RAM_LO 24'h010000
`define SINGLE_ACCESS_RAM_TOP 24'h03FFFF
`define EXT_LO 24'h050000
`define CS2_LO 24'h400000
`define CS3_LO 24'h800000
`define CS4_LO 24'hC00000
`define CS5_LO 24'hE00000
`define ROM_LO 24'hFE0000

`define RAM_BLK_LSB 13
`define ROM_BLK_LSB 15
`define SINGLE_ACCESS_RAM_BLK_BASE 5'h08
`define DUAL_ACCESS_RAM_BLOCKS 8
`define SINGLE_ACCESS_RAM_BLOCKS 24
`define ROM_BLOCKS 4
`define EXT_SPACES 5
`define DUAL_ACCESS_RAM_PORTS 2

`define IO_W 16
`define IO_WINS 22
`define IO_LO {16'h8000, 16'h7000, 16'h3B00, 16'h3A00, 16'h3000, 16'h2B00, 16'h2A00, \
  16'h2900, 16'h2800, 16'h1C00, 16'h1B00, 16'h1A00, 16'h1900, 16'h1880, 16'h1840, \
  16'h1800, 16'h1000, 16'h0F00, 16'h0E00, 16'h0D00, 16'h0C00, 16'h0000}
`define IO_HI {16'hFFFF, 16'h70FF, 16'h3B7F, 16'h3A7F, 16'h300F, 16'h2B40, 16'h2A40, \
  16'h2940, 16'h2840, 16'h1CFF, 16'h1B1F, 16'h1A6C, 16'h197F, 16'h189F, 16'h185F, \
  16'h181F, 16'h10DD, 16'h0F7F, 16'h0E7F, 16'h0D7F, 16'h0C7F, 16'h0004}
`define IO_DMA_OK 22'h2DEC20

`endif

/* File: hdl/decoder_pkg.sv */
package decoder_pkg;

  typedef enum logic [6:0]
  {
    KIND_NONE = 7'h01,
    KIND_MMR = 7'h02,
    KIND_DUAL_ACCESS_RAM = 7'h04,
    KIND_SINGLE_ACCESS_RAM = 7'h08,
    KIND_ROM = 7'h10,
    KIND_EXT = 7'h20,
    KIND_IO = 7'h40
  } region_e;

endpackage

/* File: hdl/memory_region_decode.sv */
`timescale 1ns/1ns
`include "decoder_defs.svh"
module memory_region_decode
(
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic rom_unmap_flag,
  output decoder_pkg::region_e region,
  output logic [`BLK_W-1:0] blk
);
  import decoder_pkg::*;

  wire is_mmr = addr <= `MMR_TOP;
  wire is_dual_access_ram = addr <= `DUAL_ACCESS_RAM_TOP;
  wire is_single_access_ram = addr >= `SINGLE_ACCESS_RAM_LO && addr <= `SINGLE_ACCESS_RAM_TOP;
  wire is_rom = addr >= `ROM_LO;
  wire is_ext = addr >= `EXT_LO && !is_rom;
  wire [`BLK_W-1:0] ram_blk = addr[`RAM_BLK_LSB +: `BLK_W];
  wire [`BLK_W-1:0] ext_idx = (addr >= `CS5_LO) ? 5'h04 :
    (addr >= `CS4_LO) ? 5'h03 :
    (addr >= `CS3_LO) ? 5'h02 :
    (addr >= `CS2_LO) ? 5'h01 : 5'h00;

  // 040000h..04FFFFh and an unmapped rom fall to none
  assign region = is_mmr ? KIND_MMR :
    is_dual_access_ram ? KIND_DUAL_ACCESS_RAM :
    is_single_access_ram ? KIND_SINGLE_ACCESS_RAM :
    is_ext ? KIND_EXT :
    (is_rom && !rom_unmap_flag) ? KIND_ROM : KIND_NONE;

  assign blk = is_single_access_ram ? ram_blk - `SINGLE_ACCESS_RAM_BLK_BASE :
    is_ext ? ext_idx :
    is_rom ? {3'h0, addr[`ROM_BLK_LSB +: 2]} : ram_blk;
endmodule

/* File: hdl/io_window_decode.sv */
`timescale 1ns/1ns
`include "decoder_defs.svh"
module io_window_decode
(
  input wire logic [`IO_W-1:0] word_addr,
  output logic [`IO_WINS-1:0] hit
);
  localparam logic [`IO_WINS*`IO_W-1:0] WIN_LO = `IO_LO;
  localparam logic [`IO_WINS*`IO_W-1:0] WIN_HI = `IO_HI;

  // gaps between windows hit nothing and stay reserved
  genvar w;
  generate
    for (w = 0; w < `IO_WINS; w++)
    begin : g_win
      assign hit[w] = word_addr >= WIN_LO[w*`IO_W +: `IO_W] &&
        word_addr <= WIN_HI[w*`IO_W +: `IO_W];
    end
  endgenerate
endmodule

/* File: hdl/address_decoder.sv */
`timescale 1ns/1ns
`include "decoder_defs.svh"
module address_decoder
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`MASTERS-1:0] req,
  input wire logic [`MASTERS-1:0] req_io,
  input wire logic [`MASTERS-1:0][`ADDR_W-1:0] req_addr,
  input wire logic rom_unmap_write,
  input wire logic rom_unmap_value,
  input wire logic sdram_pair_mode,
  output logic [`MASTERS-1:0] grant,
  output logic [`MASTERS-1:0] stall,
  output logic [`MASTERS-1:0] zero_read,
  output logic rom_unmap_flag,
  output logic cpu_mapped_registers_sel,
  output logic [`DUAL_ACCESS_RAM_BLOCKS-1:0] dual_access_ram_sel,
  output logic [`DUAL_ACCESS_RAM_BLOCKS-1:0] dual_access_ram_double,
  output logic [`SINGLE_ACCESS_RAM_BLOCKS-1:0] single_access_ram_sel,
  output logic [`ROM_BLOCKS-1:0] rom_sel,
  output logic [`EXT_SPACES-1:0] external_space_select_n,
  output logic sdram_space_select_b_n,
  output logic [`IO_WINS-1:0] io_window_sel,
  output logic [`IO_W-1:0] io_word_addr
);
  import decoder_pkg::*;

  localparam logic [`IO_WINS-1:0] DMA_IO_OK = `IO_DMA_OK;

  wire [`MASTERS-1:0] act;
  wire [`MASTERS-1:0] stall_now;
  wire [`MASTERS-1:0] gnt_now;
  wire [`MASTERS-1:0] zero_now;
  wire [`MASTERS-1:0] mmr_now;
  wire [11:0] key [`MASTERS];
  wire [`MASTERS-1:0] same [`MASTERS];
  wire [`DUAL_ACCESS_RAM_BLOCKS-1:0] da_oh [`MASTERS];
  wire [`SINGLE_ACCESS_RAM_BLOCKS-1:0] sa_oh [`MASTERS];
  wire [`ROM_BLOCKS-1:0] rom_oh [`MASTERS];
  wire [`EXT_SPACES-1:0] ext_oh [`MASTERS];
  wire [`IO_WINS-1:0] io_oh [`MASTERS];

  logic [`DUAL_ACCESS_RAM_BLOCKS-1:0] next_da;
  logic [`DUAL_ACCESS_RAM_BLOCKS-1:0] next_da2;
  logic [`SINGLE_ACCESS_RAM_BLOCKS-1:0] next_sa;
  logic [`ROM_BLOCKS-1:0] next_rom;
  logic [`EXT_SPACES-1:0] next_ext;
  logic [`IO_WINS-1:0] next_io;
  logic [`IO_W-1:0] next_io_addr;

  // index 0 is the CPU, 1..4 the DMA engines, 5 the USB DMA
  genvar m, k;
  generate
    for (m = 0; m < `MASTERS; m++)
    begin : g_master
      region_e mem_kind;
      region_e kind;
      logic [`BLK_W-1:0] blk;
      logic [`IO_WINS-1:0] io_hit;
      logic io_ok;

      memory_region_decode u_mem
      (
        .addr(req_addr[m]),
        .rom_unmap_flag(rom_unmap_flag),
        .region(mem_kind),
        .blk(blk)
      );

      io_window_decode u_io
      (
        .word_addr(req_addr[m][`IO_W-1:0]),
        .hit(io_hit)
      );

      // usb dma has no i/o path; dma only sees the listed windows
      assign io_ok = (m == `M_CPU) ? |io_hit :
        (m == `M_USB) ? 1'b0 : |(io_hit & DMA_IO_OK);

      assign kind = !req[m] ? KIND_NONE :
        req_io[m] ? (io_ok ? KIND_IO : KIND_NONE) :
        (m == `M_USB && (mem_kind == KIND_DUAL_ACCESS_RAM || mem_kind == KIND_MMR)) ? KIND_NONE :
        mem_kind;

      // one external_memory_interface and one i/o path: block index ignored there
      assign key[m] = {kind, (kind == KIND_EXT || kind == KIND_IO) ? 5'h00 : blk};
      assign act[m] = req[m] && kind != KIND_NONE;
      assign zero_now[m] = req[m] && kind == KIND_NONE;
      assign mmr_now[m] = gnt_now[m] && kind == KIND_MMR;

      for (k = 0; k < `MASTERS; k++)
      begin : g_peer
        if (k < m)
        begin : g_higher
          assign same[m][k] = act[k] && key[k] == key[m];
        end
        else
        begin : g_lower
          assign same[m][k] = 1'b0;
        end
      end

      // dual-access blocks serve two, everything else one
      assign stall_now[m] = act[m] && ((kind == KIND_DUAL_ACCESS_RAM) ?
        ($countones(same[m]) >= `DUAL_ACCESS_RAM_PORTS) : |same[m]);
      assign gnt_now[m] = req[m] && !stall_now[m];

      assign da_oh[m] = (gnt_now[m] && kind == KIND_DUAL_ACCESS_RAM) ?
        `DUAL_ACCESS_RAM_BLOCKS'(8'h01 << blk[2:0]) : '0;
      assign sa_oh[m] = (gnt_now[m] && kind == KIND_SINGLE_ACCESS_RAM) ?
        `SINGLE_ACCESS_RAM_BLOCKS'(24'h000001 << blk) : '0;
      assign rom_oh[m] = (gnt_now[m] && kind == KIND_ROM) ?
        `ROM_BLOCKS'(4'h1 << blk[1:0]) : '0;
      assign ext_oh[m] = (gnt_now[m] && kind == KIND_EXT) ?
        `EXT_SPACES'(5'h01 << blk[2:0]) : '0;
      assign io_oh[m] = (gnt_now[m] && kind == KIND_IO) ? io_hit : '0;
    end
  endgenerate

  always_comb
  begin
    next_da = '0;
    next_da2 = '0;
    next_sa = '0;
    next_rom = '0;
    next_ext = '0;
    next_io = '0;
    next_io_addr = '0;
    for (int i = 0; i < `MASTERS; i++)
    begin
      next_da2 = next_da2 | (next_da & da_oh[i]);
      next_da = next_da | da_oh[i];
      next_sa = next_sa | sa_oh[i];
      next_rom = next_rom | rom_oh[i];
      next_ext = next_ext | ext_oh[i];
      next_io = next_io | io_oh[i];
      if (io_oh[i] != '0)
      begin
        next_io_addr = req_addr[i][`IO_W-1:0];
      end
    end
  end

  // flag follows hardware reset only; a soft reset leaves it alone
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rom_unmap_flag <= 1'b0;
    end
    else if (rom_unmap_write)
    begin
      rom_unmap_flag <= rom_unmap_value;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      grant <= '0;
      stall <= '0;
      zero_read <= '0;
      cpu_mapped_registers_sel <= 1'b0;
      dual_access_ram_sel <= '0;
      dual_access_ram_double <= '0;
      single_access_ram_sel <= '0;
      rom_sel <= '0;
      external_space_select_n <= '1;
      sdram_space_select_b_n <= 1'b1;
      io_window_sel <= '0;
      io_word_addr <= '0;
    end
    else
    begin
      grant <= gnt_now;
      stall <= stall_now;
      zero_read <= zero_now;
      cpu_mapped_registers_sel <= |mmr_now;
      dual_access_ram_sel <= next_da;
      dual_access_ram_double <= next_da2;
      single_access_ram_sel <= next_sa;
      rom_sel <= next_rom;
      external_space_select_n <= ~next_ext;
      sdram_space_select_b_n <= ~(next_ext[0] && sdram_pair_mode);
      io_window_sel <= next_io;
      io_word_addr <= next_io_addr;
    end
  end

  // checks
  wire cpu_mem = req[0] && !req_io[0];
  wire dma0_mem = req[1] && !req_io[1];
  wire [`ADDR_W-1:0] a0 = req_addr[0];
  wire [`ADDR_W-1:0] a1 = req_addr[1];
  wire [`ADDR_W-1:0] a2 = req_addr[2];
  wire cpu_sa = a0 >= `SINGLE_ACCESS_RAM_LO && a0 <= `SINGLE_ACCESS_RAM_TOP;
  wire same_sa = a0[`RAM_BLK_LSB +: `BLK_W] == a1[`RAM_BLK_LSB +: `BLK_W];
  wire three_da = cpu_mem && dma0_mem && req[2] && !req_io[2] &&
    a0 > `MMR_TOP && a0 <= `DUAL_ACCESS_RAM_TOP && a1[23:13] == a0[23:13] && a2[23:13] == a0[23:13] &&
    a1 > `MMR_TOP && a2 > `MMR_TOP;

  a_usb_no_dual_access_ram: assert property (@(posedge ref_clk) disable iff (rst)
    (req[`M_USB] && !req_io[`M_USB] && req_addr[`M_USB] <= `DUAL_ACCESS_RAM_TOP)
    |=> (zero_read[`M_USB] && grant[`M_USB]))
    else $error("usb dma reached dual-access ram");

  a_mmr_low_bytes: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && a0 <= `MMR_TOP) |=> (cpu_mapped_registers_sel && grant[0] && !zero_read[0]))
    else $error("low bytes not sent to cpu registers");

  a_single_access_ram_priority: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && dma0_mem && cpu_sa && same_sa && a1[23:18] == a0[23:18])
    |=> (grant[0] && stall[1] && !grant[1] && $onehot(single_access_ram_sel)))
    else $error("single-access conflict not resolved by priority");

  a_dual_access_ram_two_ports: assert property (@(posedge ref_clk) disable iff (rst)
    three_da |=> (grant[0] && grant[1] && stall[2] && dual_access_ram_double != '0))
    else $error("dual-access block did not take exactly two");

  a_rom_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
    (rom_unmap_flag && cpu_mem && a0 >= `ROM_LO) |=> (zero_read[0] && external_space_select_n == '1))
    else $error("rom range still mapped with flag set");

  a_flag_load: assert property (@(posedge ref_clk) disable iff (rst)
    rom_unmap_write |=> (rom_unmap_flag == $past(rom_unmap_value)))
    else $error("rom unmap flag did not load");

  a_sdram_pair: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && a0 >= `EXT_LO && a0 < `CS2_LO)
    |=> (!external_space_select_n[0] && sdram_space_select_b_n == !$past(sdram_pair_mode)))
    else $error("sdram space selects wrong");

  a_ext_top_space: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && a0 >= `CS5_LO && a0 < `ROM_LO && !rom_unmap_flag)
    |=> (!external_space_select_n[4] && $countones(~external_space_select_n) == 1))
    else $error("top external space not selected alone");

  a_io_gap_empty: assert property (@(posedge ref_clk) disable iff (rst)
    (req[0] && req_io[0] && a0[15:0] >= 16'h1D00 && a0[15:0] <= 16'h27FF) |=> zero_read[0])
    else $error("reserved i/o gap selected a window");

  a_dma_io_filter: assert property (@(posedge ref_clk) disable iff (rst)
    (req[1] && req_io[1] && a1[15:0] >= 16'h1800 && a1[15:0] <= 16'h181F) |=> zero_read[1])
    else $error("dma reached a timer window");

  a_usb_no_io: assert property (@(posedge ref_clk) disable iff (rst)
    (req[`M_USB] && req_io[`M_USB]) |=> (zero_read[`M_USB] && grant[`M_USB]))
    else $error("usb dma reached i/o space");

  a_io_addr_word: assert property (@(posedge ref_clk) disable iff (rst)
    (req[0] && req_io[0] && !zero_now[0]) |=> (grant[0] && io_word_addr == $past(a0[15:0])))
    else $error("i/o word address not passed on");

  a_mem_gap_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && a0 > `SINGLE_ACCESS_RAM_TOP && a0 < `EXT_LO) |=> (zero_read[0] && grant[0]))
    else $error("reserved memory gap selected something");

  a_idle_gap_empty: assert property (@(posedge ref_clk) disable iff (rst)
    (req[0] && req_io[0] && a0[15:0] >= 16'h0005 && a0[15:0] <= 16'h0BFF) |=> zero_read[0])
    else $error("reserved low i/o gap selected a window");

  a_external_memory_interface_gap_empty: assert property (@(posedge ref_clk) disable iff (rst)
    (req[0] && req_io[0] && a0[15:0] >= 16'h10EE && a0[15:0] <= 16'h17FF) |=> zero_read[0])
    else $error("reserved i/o gap after external_memory_interface selected a window");

  a_grant_or_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (grant & stall) == '0)
    else $error("master granted and stalled together");

  a_rom_mapped: assert property (@(posedge ref_clk) disable iff (rst)
    (!rom_unmap_flag && cpu_mem && a0 >= `ROM_LO) |=> (rom_sel != '0 && !zero_read[0] && grant[0]))
    else $error("rom range not mapped with flag clear");

  a_dual_access_ram_select: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_mem && a0 > `MMR_TOP && a0 <= `DUAL_ACCESS_RAM_TOP) |=> (dual_access_ram_sel != '0 && grant[0]))
    else $error("dual-access range not selected");
endmodule

/* File: verification/master_model.sv */
`timescale 1ns/1ns
`include "decoder_defs.svh"
module master_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`MASTERS-1:0] issue,
  input wire logic [`MASTERS-1:0] issue_io,
  input wire logic [`MASTERS-1:0][`ADDR_W-1:0] issue_addr,
  input wire logic [`MASTERS-1:0] grant,
  output logic [`MASTERS-1:0] req,
  output logic [`MASTERS-1:0] req_io,
  output logic [`MASTERS-1:0][`ADDR_W-1:0] req_addr,
  output logic busy
);
  logic [`MASTERS-1:0] pending;
  logic [`MASTERS-1:0] hold_io;
  logic [`MASTERS-1:0][`ADDR_W-1:0] hold_addr;
  // grant shows a cycle late, so drop in that cycle or it counts twice
  assign req = pending & ~grant;
  assign busy = |pending;
  // peripherals taken as out of reset and clocked
  always_comb
  begin
    for (int m = 0; m < `MASTERS; m++)
    begin
      // released lines show the inverse so a stale address never matches
      req_io[m] = req[m] ? hold_io[m] : ~hold_io[m];
      req_addr[m] = req[m] ? hold_addr[m] : ~hold_addr[m];
    end
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pending <= '0;
      hold_io <= '0;
      hold_addr <= '0;
    end
    else
    begin
      pending <= (pending & ~grant) | issue;
      for (int m = 0; m < `MASTERS; m++)
      begin
        if (issue[m])
        begin
          hold_io[m] <= issue_io[m];
          hold_addr[m] <= issue_addr[m];
        end
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`include "decoder_defs.svh"
module testbench;
  typedef logic [106:0] obs_t;
  localparam logic [21:0] DMA_OK = 22'h2DEC20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] issue = 6'h00;
  logic [5:0] issue_io = 6'h00;
  logic [5:0][23:0] issue_addr = '0;
  logic rom_unmap_write = 1'b0;
  logic rom_unmap_value = 1'b0;
  logic sdram_pair_mode = 1'b0;
  logic [5:0] req, req_io, grant, stall, zero_read, pm, pio;
  logic [5:0][23:0] req_addr, pad;
  logic rom_unmap_flag, cpu_mapped_registers_sel, sdram_space_select_b_n, busy, rom_off;
  logic [7:0] dual_access_ram_sel, dual_access_ram_double;
  logic [23:0] single_access_ram_sel;
  logic [3:0] rom_sel;
  logic [4:0] external_space_select_n;
  logic [21:0] io_window_sel;
  logic [15:0] io_word_addr;
  obs_t notes[$];
  obs_t seen;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h4F;
  logic [23:0] mem_a [19] = '{24'h000000, 24'h0000BF, 24'h0000C0, 24'h001FFF, 24'h00E000, 24'h010000,
    24'h03FFFF, 24'h040000, 24'h04FFFF, 24'h050000, 24'h3FFFFF, 24'h400000, 24'h7FFFFF, 24'h800000,
    24'hC00000, 24'hE00000, 24'hFDFFFF, 24'hFE0000, 24'hFFFFFF};
  // reserved points break the avoid-reserved habit on purpose
  logic [15:0] io_a [28] = '{16'h0004, 16'h0005, 16'h0BFF, 16'h0C00, 16'h0D00, 16'h0E7F, 16'h0F7F,
    16'h10DD, 16'h10EE, 16'h17FF, 16'h1800, 16'h1840, 16'h189F, 16'h1900, 16'h1A00, 16'h1B1F, 16'h1CFF,
    16'h1D00, 16'h27FF, 16'h2840, 16'h2900, 16'h2A40, 16'h2B00, 16'h3000, 16'h3A00, 16'h3B7F, 16'h70FF,
    16'h8000};
  int io_w [28] = '{0, 31, 31, 1, 2, 3, 4, 5, 31, 31, 6, 7, 8, 9, 10, 11, 12, 31, 31, 13, 14, 15, 16, 17,
    18, 19, 20, 21};
  address_decoder address_decoder_i (.ref_clk, .rst, .req, .req_io, .req_addr, .rom_unmap_write,
    .rom_unmap_value, .sdram_pair_mode, .grant, .stall, .zero_read, .rom_unmap_flag,
    .cpu_mapped_registers_sel, .dual_access_ram_sel, .dual_access_ram_double, .single_access_ram_sel,
    .rom_sel, .external_space_select_n, .sdram_space_select_b_n, .io_window_sel, .io_word_addr);
  master_model master_model_i (.ref_clk, .rst, .issue, .issue_io, .issue_addr, .grant, .req, .req_io,
    .req_addr, .busy);
  assign seen = {io_word_addr, grant, stall, zero_read, cpu_mapped_registers_sel, dual_access_ram_sel,
    dual_access_ram_double, single_access_ram_sel, rom_sel, ~external_space_select_n,
    ~sdram_space_select_b_n, io_window_sel};
  always #25 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic obs_t exp1(int m, logic io, logic [23:0] a, int w);
    obs_t v;
    v = '0;
    v[85 + m] = 1'b1;
    if (io && (w == 31 || m == 5 || (m > 0 && !DMA_OK[w]))) v[73 + m] = 1'b1;
    else if (io)
    begin
      v[w] = 1'b1;
      v[106:91] = a[15:0];
    end
    else if (m == 5 && a <= 24'h00FFFF) v[73 + m] = 1'b1;
    else if (a <= 24'h0000BF) v[72] = 1'b1;
    else if (a <= 24'h00FFFF) v[64 + a[15:13]] = 1'b1;
    else if (a <= 24'h03FFFF) v[24 + a[17:13]] = 1'b1;
    else if (a < 24'h050000 || (a >= 24'hFE0000 && rom_off)) v[73 + m] = 1'b1;
    else if (a >= 24'hFE0000) v[28 + a[16:15]] = 1'b1;
    else
    begin
      v[23 + (a < 24'h400000 ? 0 : a < 24'h800000 ? 1 : a < 24'hC00000 ? 2 : a < 24'hE00000 ? 3 : 4)] = 1'b1;
      v[22] = a < 24'h400000 && sdram_pair_mode;
    end
    return v;
  endfunction
  task automatic check(logic ok, string msg);
    samples_checked++;
    if (!ok)
    begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    if (notes.size() != 0) num_errors++;
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic put(int m, logic io, logic [23:0] a);
    pm[m] = 1'b1;
    pio[m] = io;
    pad[m] = a;
  endtask
  task automatic fire();
    int n;
    @(posedge ref_clk);
    issue <= pm;
    issue_io <= pio;
    issue_addr <= pad;
    pm = 6'h00;
    @(posedge ref_clk);
    issue <= 6'h00;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (busy !== 1'b0 && n < 20);
    @(posedge ref_clk);
  endtask
  task automatic one(int m, logic io, logic [23:0] a, int w);
    put(m, io, a);
    notes.push_back(exp1(m, io, a, w));
    fire();
  endtask
  task automatic both(int a, int b, logic io, logic [23:0] x, logic [23:0] y, int wa, int wb, logic clash);
    put(a, io, x);
    put(b, io, y);
    if (clash)
    begin
      notes.push_back(exp1(a, io, x, wa) | (obs_t'(1'b1) << (79 + b)));
      notes.push_back(exp1(b, io, y, wb));
    end
    else notes.push_back(exp1(a, io, x, wa) | exp1(b, io, y, wb));
    fire();
  endtask
  task automatic setflag(logic v);
    @(posedge ref_clk);
    rom_unmap_write <= 1'b1;
    rom_unmap_value <= v;
    @(posedge ref_clk);
    rom_unmap_write <= 1'b0;
    @(negedge ref_clk);
    check(rom_unmap_flag === v, "rom unmap flag");
    rom_off = v;
  endtask
  always @(negedge ref_clk)
  begin
    if (!rst && (grant | stall) !== 6'h00)
    begin
      if (notes.size() == 0) check(1'b0, "unexpected grant");
      else check(seen === notes.pop_front(), "decode result");
    end
  end
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    rom_off = 1'b0;
    pm = 6'h00;
    pio = 6'h00;
    pad = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      sdram_pair_mode <= p[0];
      for (int i = 0; i < 19; i++)
        for (int k = 0; k < 3; k++)
          one(k * 2 + k / 2, 1'b0, mem_a[i], 0);
    end
    for (int i = 0; i < 28; i++)
      for (int m = 0; m < 6; m++)
        one(m, 1'b1, {8'h00, io_a[i]}, io_w[i]);
    setflag(1'b1);
    for (int i = 16; i < 19; i++) one(0, 1'b0, mem_a[i], 0);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    check(rom_unmap_flag === 1'b0 && external_space_select_n === 5'h1F && grant === 6'h00, "reset state");
    rom_off = 1'b0;
    @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 16; i < 19; i++) one(5, 1'b0, mem_a[i], 0);
    both(0, 1, 1'b0, 24'h010000, 24'h011FFE, 0, 0, 1'b1);
    both(3, 5, 1'b0, 24'h03E000, 24'h03E010, 0, 0, 1'b1);
    both(0, 1, 1'b0, 24'h010000, 24'h012000, 0, 0, 1'b0);
    both(0, 1, 1'b0, 24'h002000, 24'h00E000, 0, 0, 1'b0);
    both(1, 2, 1'b0, 24'hFE0000, 24'hFE7FFE, 0, 0, 1'b1);
    both(0, 4, 1'b0, 24'h050000, 24'hE00000, 0, 0, 1'b1);
    both(0, 1, 1'b1, 24'h001A00, 24'h001B00, 10, 11, 1'b1);
    put(0, 1'b0, 24'h006000);
    put(1, 1'b0, 24'h006002);
    put(2, 1'b0, 24'h007FFE);
    notes.push_back(exp1(0, 1'b0, 24'h006000, 0) | exp1(1, 1'b0, 24'h006002, 0)
      | (obs_t'(1'b1) << 59) | (obs_t'(1'b1) << 81));
    notes.push_back(exp1(2, 1'b0, 24'h007FFE, 0));
    fire();
    repeat (60)
    begin
      rnd = xs(rnd);
      one(rnd[26:24] % 6, 1'b0, rnd[23:0], 0);
    end
    complete_run();
  end
endmodule
